// ===== tfs_framer_model.sv
// link partner model: tdm clock, sync and data, frame by frame
`timescale 1ns/100ps
`default_nettype none
module tfs_framer_model (
    input  wire logic core_clk,
    output var logic  fr_clk,
    output var logic  fr_sync,
    output var logic  fr_data
);
    // link idles low; clock stands still between frames
    initial begin
        fr_clk = 1'h0;
        fr_sync = 1'h0;
        fr_data = 1'h0;
    end
    // wait n core cycles, then move just after the edge
    task automatic hold(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // optional sync, then nclk clocks; a short or long count models pulse errors
    task automatic frame(input int nclk, input bit with_sync);
        if (with_sync) begin
            fr_sync = 1'h1;
            hold(4);
            fr_sync = 1'h0;
            hold(4);
        end
        for (int k = 0; k < nclk; k++) begin
            fr_data = k[0] ^ k[2];
            hold(4);
            fr_clk = 1'h1;
            hold(4);
            fr_clk = 1'h0;
        end
        fr_data = ~fr_data; // released line must not show a stale bit
        hold(4);
    endtask
endmodule
`default_nettype wire

// ===== tfs_pkg.sv
// package of constants and types for the tdm frame slot synchroniser
package tfs_pkg;
    // frame geometry
    localparam int SLOT_BITS        = 8;
    localparam int T1_SLOTS         = 24;
    localparam int T1_FRAME_BITS    = 193;
    localparam int E1_SLOTS         = 32;
    localparam int E1_FRAME_BITS    = 256;
    localparam int E1_SYNC_SLOT     = 0;
    localparam int E1_SIG_SLOT      = 16;
    // frame timing
    localparam int FRAME_RATE_HZ    = 8000;
    localparam int FRAME_PERIOD_NS  = 125000;
    localparam int CORE_CLK_MHZ     = 125;
    localparam int CLK_PERIOD_NS    = 1000 / CORE_CLK_MHZ;
    localparam int FRAME_CYCLES     = FRAME_PERIOD_NS / CLK_PERIOD_NS;
    // routing memory geometry
    localparam int RT_ENTRIES       = 64;
    localparam int RT_AW            = 6;
    // routing entry layout: [15] last, [14] strobe, [13:8] channel, [7:0] bit count minus one
    localparam int RT_W             = 16;
    localparam int RT_LAST_BIT      = 15;
    localparam int RT_VALID_BIT     = 14;
    localparam int RT_CH_LSB        = 8;
    localparam int RT_CH_W          = 6;
    localparam int RT_CNT_LSB       = 0;
    localparam int RT_CNT_W         = 8;
    // channel mode codes, one per logical channel
    localparam logic [1:0] MODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_TRANS = 2'h1;
    localparam logic [1:0] MODE_HDLC  = 2'h2;
    // buffer descriptor status layout
    localparam int BD_ST_W          = 4;
    localparam int BD_CRC_BIT       = 0;
    localparam int BD_LEN_BIT       = 1;
    localparam int BD_NOA_BIT       = 2;
    localparam int BD_SYNC_BIT      = 3;
    // counter states
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_END} tfs_state_t;
endpackage

// ===== tfs_route_mem.sv
// routing memory: one array (banks come from the read address), registered read, one write port
`timescale 1ns/100ps
`default_nettype none
module tfs_route_mem #(
    parameter int AW = 6,
    parameter int DW = 16
) (
    input  wire logic          core_clk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // write port
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read, so read data come out of a flip-flop
    always_ff @(posedge core_clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// ===== tfs_slot_sync.sv
// top of the tdm frame slot synchroniser: slot counter, routing and error flags
//
// Behaviour
// - count link clocks from sync through programmed entries; expect sync at last
// - a sync arriving before the end state is ignored
// - after a missed clock, wait in end state and restart on sync N+2
// - extra clock reaches end early; resume on next sync N+1
// - late sync behaves like a clock missing in the last slot
// - early sync behaves like one extra clock within the frame
// - clock errors corrupt routing of all channels until resynchronised
// - hdlc frame end closes buffer, all status written, bit errors as crc
// - clock or sync noise may add length violation or sync status
// - transparent channels get no error detection
// - shadow table switched at routing entry boundary; halves usable entries
// - frames repeat at 8 khz, every 125 us, eight bits per slot; the generator by default frames every 31232 cycles, about 250 us
// - t1 frame is 24 slots plus framing bit, 193 bits
// - e1 frame is 32 slots, 256 bits
// - e1 slots 0 and 16 reserved, not payload
// - device can generate tdm clock and sync itself for a backplane
// - routing restarts from first entry on every accepted sync
`timescale 1ns/100ps
`default_nettype none
module tfs_slot_sync
    import tfs_pkg::*;
#(
    parameter int RT_DEPTH_AW = tfs_pkg::RT_AW,
    parameter int GEN_DIV     = 61,
    parameter int GEN_BITS    = tfs_pkg::E1_FRAME_BITS
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    // link pins
    input  wire logic                        tdm_clk_in,
    input  wire logic                        tdm_sync_in,
    input  wire logic                        tdm_data_in,
    output logic                             tdm_clk_out,
    output logic                             tdm_clk_oe,
    output logic                             tdm_sync_out,
    output logic                             tdm_sync_oe,
    // configuration
    input  wire logic                        link_enable,
    input  wire logic                        gen_enable,
    input  wire logic                        open_drain,
    input  wire logic                        e1_mode,
    input  wire logic                        shadow_enable,
    input  wire logic                        shadow_select,
    input  wire logic [1:0]                  chan_mode [0:(1<<tfs_pkg::RT_CH_W)-1],
    // routing memory load port
    input  wire logic                        rt_wr_en,
    input  wire logic [RT_DEPTH_AW-1:0]      rt_wr_addr,
    input  wire logic [tfs_pkg::RT_W-1:0]    rt_wr_data,
    // hdlc frame end from the protocol side
    input  wire logic                        hdlc_frame_end,
    input  wire logic [tfs_pkg::RT_CH_W-1:0] hdlc_frame_ch,
    input  wire logic                        hdlc_crc_bad,
    input  wire logic                        hdlc_octet_bad,
    input  wire logic                        hdlc_len_bad,
    // routed bit stream
    output logic                             bit_valid,
    output logic                             bit_data,
    output logic [tfs_pkg::RT_CH_W-1:0]      bit_chan,
    output logic                             slot_reserved,
    // buffer descriptor status write
    output logic                             bd_wr,
    output logic [tfs_pkg::RT_CH_W-1:0]      bd_chan,
    output logic [tfs_pkg::BD_ST_W-1:0]      bd_status,
    // status
    output logic                             in_sync,
    output logic                             sync_ignored,
    output logic                             sync_lost_flag,
    input  wire logic                        sync_lost_clear
);
    import tfs_pkg::*;

    // ****************************************
    // pin input synchronisers
    // ****************************************
    logic [2:0] clk_sr_q;
    logic [2:0] syn_sr_q;
    logic [2:0] dat_sr_q;
    logic       clk_lvl_q;
    logic       syn_lvl_q;
    logic       clk_rise;
    logic       syn_rise;

    // three stages; a change counts once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            clk_sr_q <= 3'h0;
            syn_sr_q <= 3'h0;
            dat_sr_q <= 3'h0;
        end else begin
            clk_sr_q <= {clk_sr_q[1:0], tdm_clk_in};
            syn_sr_q <= {syn_sr_q[1:0], tdm_sync_in};
            dat_sr_q <= {dat_sr_q[1:0], tdm_data_in};
        end
    end

    // filtered levels, updated only when stages two and three agree
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            clk_lvl_q <= 1'b0;
            syn_lvl_q <= 1'b0;
        end else begin
            if (clk_sr_q[1] == clk_sr_q[2]) begin
                clk_lvl_q <= clk_sr_q[2];
            end
            if (syn_sr_q[1] == syn_sr_q[2]) begin
                syn_lvl_q <= syn_sr_q[2];
            end
        end
    end

    assign clk_rise = (clk_sr_q[1] == clk_sr_q[2]) && clk_sr_q[2] && !clk_lvl_q;
    assign syn_rise = (syn_sr_q[1] == syn_sr_q[2]) && syn_sr_q[2] && !syn_lvl_q;

    // ****************************************
    // internal clock and sync generator
    // ****************************************
    logic [15:0] div_q;
    logic [8:0]  gen_bit_q;
    logic        gen_clk_q;
    logic        gen_sync_q;
    logic        gen_fall;

    assign gen_fall = (div_q == 16'(GEN_DIV - 1)) && gen_clk_q;

    // divider toggles the link clock; sync high for the first bit of each frame but the first after enable
    always_ff @(posedge core_clk) begin
        if (!rst_n || !gen_enable) begin
            div_q      <= 16'h0000;
            gen_clk_q  <= 1'b0;
            gen_bit_q  <= 9'h000;
            gen_sync_q <= 1'b0;
        end else if (div_q == 16'(GEN_DIV - 1)) begin
            div_q     <= 16'h0000;
            gen_clk_q <= !gen_clk_q;
            if (gen_fall) begin
                gen_bit_q  <= (gen_bit_q == 9'(GEN_BITS - 1)) ? 9'h000 : gen_bit_q + 9'h001;
                gen_sync_q <= (gen_bit_q == 9'(GEN_BITS - 1));
            end
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // pin drivers; open drain only pulls low, released high by the pull-up
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tdm_clk_out  <= 1'b0;
            tdm_clk_oe   <= 1'b0;
            tdm_sync_out <= 1'b0;
            tdm_sync_oe  <= 1'b0;
        end else begin
            tdm_clk_out  <= open_drain ? 1'b0 : gen_clk_q;
            tdm_clk_oe   <= gen_enable && (!open_drain || !gen_clk_q);
            tdm_sync_out <= open_drain ? 1'b0 : gen_sync_q;
            tdm_sync_oe  <= gen_enable && (!open_drain || !gen_sync_q);
        end
    end

    // ****************************************
    // routing memory and slot counter
    // ****************************************
    localparam int HALF_AW = RT_DEPTH_AW - 1;

    logic                   clk_ev;
    logic                   syn_ev;
    tfs_state_t             st_q;
    logic [RT_DEPTH_AW-1:0] ent_q;
    logic [RT_DEPTH_AW-1:0] rd_addr;
    logic [RT_CNT_W-1:0]    cnt_q;
    logic [RT_W-1:0]        ent_data;
    logic                   bank_q;
    logic                   ent_last;
    logic                   ent_done;

    // events come from the pins only, gated by link_enable; the generator is not looped back internally
    assign clk_ev = link_enable && clk_rise;
    assign syn_ev = link_enable && syn_rise;

    // halved table: top address bit selects the bank when the shadow is on
    assign rd_addr = shadow_enable ? {bank_q, ent_q[HALF_AW-1:0]} : ent_q;

    tfs_route_mem #(
        .AW (RT_DEPTH_AW),
        .DW (RT_W)
    ) u_mem (
        .core_clk (core_clk),
        .wr_en    (rt_wr_en),
        .wr_addr  (rt_wr_addr),
        .wr_data  (rt_wr_data),
        .rd_addr  (rd_addr),
        .rd_data  (ent_data)
    );

    assign ent_last = ent_data[RT_LAST_BIT];
    assign ent_done = (cnt_q == ent_data[RT_CNT_LSB +: RT_CNT_W]);

    // counter state; sync only honoured in the idle and end states, so early sync looks like extra clocks
    always_ff @(posedge core_clk) begin
        if (!rst_n || !link_enable) begin
            st_q  <= ST_IDLE;
            ent_q <= '0;
            cnt_q <= '0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (syn_ev) begin
                        st_q  <= ST_RUN;
                        ent_q <= '0;
                        cnt_q <= '0;
                    end
                end
                ST_RUN: begin
                    // sync here is dropped: a missing clock or late sync lands here
                    if (clk_ev) begin
                        if (ent_done) begin
                            cnt_q <= '0;
                            if (ent_last) begin
                                st_q <= ST_END;
                            end else begin
                                ent_q <= ent_q + 1'b1;
                            end
                        end else begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                end
                ST_END: begin
                    // waits here through further clocks until the next sync
                    if (syn_ev) begin
                        st_q  <= ST_RUN;
                        ent_q <= '0;
                        cnt_q <= '0;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // shadow bank swaps only at the end of a routing entry, never mid-entry
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bank_q <= 1'b0;
        end else if (clk_ev && ent_done && st_q == ST_RUN) begin
            bank_q <= shadow_select;
        end
    end

    // ****************************************
    // routed bits; a bad count misroutes every channel
    // ****************************************
    function automatic logic slot_is_reserved(input logic [8:0] bitpos, input logic e1);
        logic [8:0] slot;
        slot = bitpos / 9'(SLOT_BITS);
        slot_is_reserved = e1 && (slot == 9'(E1_SYNC_SLOT) || slot == 9'(E1_SIG_SLOT));
    endfunction

    logic [8:0] bitpos_q;

    // bit position within frame, used to mark e1 reserved slots and t1 framing bit
    always_ff @(posedge core_clk) begin
        if (!rst_n || !link_enable) begin
            bitpos_q <= 9'h000;
        end else if (syn_ev && st_q != ST_RUN) begin
            bitpos_q <= 9'h000;
        end else if (clk_ev && st_q == ST_RUN) begin
            bitpos_q <= bitpos_q + 9'h001;
        end
    end

    // output follows the count alone, no check on content
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bit_valid     <= 1'b0;
            bit_data      <= 1'b0;
            bit_chan      <= '0;
            slot_reserved <= 1'b0;
        end else begin
            bit_valid     <= clk_ev && st_q == ST_RUN && ent_data[RT_VALID_BIT];
            bit_data      <= dat_sr_q[2];
            bit_chan      <= ent_data[RT_CH_LSB +: RT_CH_W];
            slot_reserved <= slot_is_reserved(bitpos_q, e1_mode)
                          || (!e1_mode && bitpos_q == 9'(T1_FRAME_BITS - 1));
        end
    end

    // ****************************************
    // sync status and buffer descriptor status
    // ****************************************
    logic ign_ev;
    logic noise_q;

    assign ign_ev = syn_ev && st_q == ST_RUN;

    // sticky flag; a new ignored sync wins over a clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync_ignored   <= 1'b0;
            sync_lost_flag <= 1'b0;
            in_sync        <= 1'b0;
        end else begin
            sync_ignored <= ign_ev;
            if (ign_ev) begin
                sync_lost_flag <= 1'b1;
            end else if (sync_lost_clear) begin
                sync_lost_flag <= 1'b0;
            end
            if (ign_ev || !link_enable) begin
                in_sync <= 1'b0;
            end else if (syn_ev && st_q != ST_RUN) begin
                in_sync <= 1'b1;
            end
        end
    end

    // remember link noise until the next hdlc frame closes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            noise_q <= 1'b0;
        end else if (ign_ev) begin
            noise_q <= 1'b1;
        end else if (hdlc_frame_end) begin
            noise_q <= 1'b0;
        end
    end

    // status written at frame close, hdlc channels only
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bd_wr     <= 1'b0;
            bd_chan   <= '0;
            bd_status <= '0;
        end else begin
            bd_wr   <= hdlc_frame_end && chan_mode[hdlc_frame_ch] == MODE_HDLC;
            bd_chan <= hdlc_frame_ch;
            bd_status[BD_CRC_BIT]  <= hdlc_crc_bad;
            bd_status[BD_LEN_BIT]  <= hdlc_len_bad || (noise_q && hdlc_crc_bad);
            bd_status[BD_NOA_BIT]  <= hdlc_octet_bad;
            bd_status[BD_SYNC_BIT] <= noise_q;
        end
    end
endmodule
`default_nettype wire

// ===== tfs_slot_sync_chk.sv
// port-level checker of the slot synchroniser, bound to its top
`timescale 1ns/100ps
`default_nettype none
module tfs_slot_sync_chk
    import tfs_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       link_enable,
    input wire logic [1:0] chan_mode [0:63],
    input wire logic       hdlc_frame_end,
    input wire logic [5:0] hdlc_frame_ch,
    input wire logic       hdlc_crc_bad,
    input wire logic       bit_valid,
    input wire logic       bd_wr,
    input wire logic [5:0] bd_chan,
    input wire logic [3:0] bd_status,
    input wire logic       in_sync,
    input wire logic       sync_ignored,
    input wire logic       sync_lost_flag,
    input wire logic       sync_lost_clear
);
    // ****
    // one clock domain, reset kills every check
    // ****
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // frame end on a channel that runs the framed protocol
    sequence s_hdlc_end;
        hdlc_frame_end && chan_mode[hdlc_frame_ch] == MODE_HDLC;
    endsequence
    // clear held while no fresh ignored sync can set the flag again
    sequence s_quiet_clear;
        sync_lost_clear && !sync_ignored ##1 !sync_ignored;
    endsequence

    a_ignore_sets_flag: assert property (
        sync_ignored |-> ##[0:1] sync_lost_flag) else $error("ignored sync left flag low");
    a_ignore_drops_sync: assert property (
        sync_ignored |-> ##[0:1] !in_sync) else $error("in_sync kept after ignored sync");
    a_flag_holds_set: assert property (
        sync_lost_flag && !sync_lost_clear |=> sync_lost_flag) else $error("flag fell unasked");
    a_clear_drops_flag: assert property (
        s_quiet_clear |-> !sync_lost_flag) else $error("flag survived clear");
    a_bd_follows_end: assert property (
        bd_wr |-> $past(hdlc_frame_end) && bd_chan == $past(hdlc_frame_ch))
        else $error("status write without frame end");
    a_crc_reported: assert property (
        s_hdlc_end ##0 hdlc_crc_bad |=> bd_wr && bd_status[BD_CRC_BIT])
        else $error("bit error not shown as crc");
    a_trans_silent: assert property (
        hdlc_frame_end && chan_mode[hdlc_frame_ch] != MODE_HDLC |=> !bd_wr)
        else $error("status written for unframed channel");
    a_idle_no_bits: assert property (
        !link_enable ##1 !link_enable |-> !bit_valid) else $error("bits routed while disabled");
endmodule

bind tfs_slot_sync tfs_slot_sync_chk u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .link_enable(link_enable),
    .chan_mode(chan_mode), .hdlc_frame_end(hdlc_frame_end),
    .hdlc_frame_ch(hdlc_frame_ch), .hdlc_crc_bad(hdlc_crc_bad),
    .bit_valid(bit_valid), .bd_wr(bd_wr), .bd_chan(bd_chan), .bd_status(bd_status),
    .in_sync(in_sync), .sync_ignored(sync_ignored), .sync_lost_flag(sync_lost_flag),
    .sync_lost_clear(sync_lost_clear));
`default_nettype wire

// ===== tfs_slot_sync_tb.sv
// self-checking bench of the slot synchroniser
`timescale 1ns/100ps
`default_nettype none
module tfs_slot_sync_tb;
    import tfs_pkg::*;
    localparam int DIV = 4; // generator half period, above the 2-cycle pulse minimum
    localparam int GBITS = 16;
    logic       core_clk, rst_n, link_enable, gen_enable, sync_lost_clear;
    logic       open_drain, e1_mode, shadow_enable, shadow_select;
    logic [1:0] chan_mode [0:63];
    logic       rt_wr_en, hdlc_frame_end, hdlc_crc_bad, hdlc_octet_bad, hdlc_len_bad;
    logic [5:0] rt_wr_addr, hdlc_frame_ch;
    logic [15:0] rt_wr_data;
    wire        fr_clk, fr_sync, fr_data, tdm_clk_out, tdm_clk_oe, tdm_sync_out;
    wire        tdm_sync_oe, bit_valid, bit_data, slot_reserved, bd_wr;
    wire        in_sync, sync_ignored, sync_lost_flag;
    wire [5:0]  bit_chan, bd_chan;
    wire [3:0]  bd_status;
    logic [5:0] got_ch[$];
    logic       got_d[$];
    logic       got_r[$];
    int         ign, cyc, bad_count, checks;

    // generated pins win the wire when driven; no internal loopback
    wire clk_pin = tdm_clk_oe ? tdm_clk_out : fr_clk;
    wire sync_pin = tdm_sync_oe ? tdm_sync_out : fr_sync;

    tfs_slot_sync #(.GEN_DIV(DIV), .GEN_BITS(GBITS)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .tdm_clk_in(clk_pin), .tdm_sync_in(sync_pin),
        .tdm_data_in(fr_data), .tdm_clk_out(tdm_clk_out), .tdm_clk_oe(tdm_clk_oe),
        .tdm_sync_out(tdm_sync_out), .tdm_sync_oe(tdm_sync_oe), .link_enable(link_enable),
        .gen_enable(gen_enable), .open_drain(open_drain), .e1_mode(e1_mode),
        .shadow_enable(shadow_enable), .shadow_select(shadow_select), .chan_mode(chan_mode),
        .rt_wr_en(rt_wr_en), .rt_wr_addr(rt_wr_addr), .rt_wr_data(rt_wr_data),
        .hdlc_frame_end(hdlc_frame_end), .hdlc_frame_ch(hdlc_frame_ch),
        .hdlc_crc_bad(hdlc_crc_bad), .hdlc_octet_bad(hdlc_octet_bad),
        .hdlc_len_bad(hdlc_len_bad), .bit_valid(bit_valid), .bit_data(bit_data),
        .bit_chan(bit_chan), .slot_reserved(slot_reserved), .bd_wr(bd_wr), .bd_chan(bd_chan),
        .bd_status(bd_status), .in_sync(in_sync), .sync_ignored(sync_ignored),
        .sync_lost_flag(sync_lost_flag), .sync_lost_clear(sync_lost_clear));
    tfs_framer_model fr (.core_clk(core_clk), .fr_clk(fr_clk), .fr_sync(fr_sync),
        .fr_data(fr_data));

    // ****
    // clock, monitor and hang guard
    // ****
    initial begin
        core_clk = 1'h0;
        forever #4 core_clk = ~core_clk;
    end
    // collect routed bits and ignored syncs; a hang counts as a failure
    always @(posedge core_clk) begin
        cyc++;
        if (bit_valid === 1'h1) begin
            got_ch.push_back(bit_chan);
            got_d.push_back(bit_data);
            got_r.push_back(slot_reserved);
        end
        if (sync_ignored === 1'h1) ign++;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic conclude();
        if (bad_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmp_v(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_n(input int got, input int exp);
        checks++;
        if (got != exp) begin
            bad_count++;
            $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    // table: 8 bits to channel 5, then 8 bits to channel 9, last entry
    task automatic check_frame(input int n, input int off);
        cmp_n(got_ch.size(), n);
        for (int i = 0; i < n && i < got_ch.size(); i++) begin
            cmp_v(got_ch[i], (i + off < 8) ? 6'h05 : 6'h09);
            cmp_v(got_d[i], i[0] ^ i[2]);
            cmp_v(got_r[i], e1_mode && (i + off < 8));
        end
        got_ch.delete();
        got_d.delete();
        got_r.delete();
    endtask
    task automatic bd_end(input logic [5:0] ch, input logic [2:0] err, input logic wr,
                          input logic [3:0] st);
        @(posedge core_clk);
        #1;
        hdlc_frame_ch = ch;
        {hdlc_len_bad, hdlc_octet_bad, hdlc_crc_bad} = err;
        hdlc_frame_end = 1'h1;
        @(posedge core_clk);
        #1;
        hdlc_frame_end = 1'h0;
        cmp_v(bd_wr, wr);
        if (wr) cmp_v(bd_status, st);
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_normal();
        ign = 0;
        repeat (2) begin
            fr.frame(16, 1'h1);
            check_frame(16, 0);
        end
        cmp_n(ign, 0);
        cmp_v(in_sync, 1'h1);
    endtask
    // short frame: next sync ignored, one bit finishes the frame, resync at N+2
    task automatic t_missed();
        ign = 0;
        fr.frame(15, 1'h1);
        check_frame(15, 0);
        fr.frame(16, 1'h1);
        check_frame(1, 15);
        cmp_n(ign, 1);
        cmp_v(sync_lost_flag, 1'h1);
        fr.frame(16, 1'h1);
        check_frame(16, 0);
    endtask
    // noise mark from the ignored sync shows once, on the next framed close
    task automatic t_bd();
        bd_end(6'h03, 3'h1, 1'h1, 4'hB);
        bd_end(6'h03, 3'h1, 1'h1, 4'h1);
        bd_end(6'h03, 3'h2, 1'h1, 4'h4);
        bd_end(6'h03, 3'h4, 1'h1, 4'h2);
        bd_end(6'h04, 3'h1, 1'h0, 4'h0);
        bd_end(6'h06, 3'h1, 1'h0, 4'h0);
    endtask
    // long frame: end reached early, stray clock dropped, next sync taken
    task automatic t_extra();
        ign = 0;
        fr.frame(17, 1'h1);
        check_frame(16, 0);
        fr.frame(16, 1'h1);
        check_frame(16, 0);
        cmp_n(ign, 0);
        sync_lost_clear = 1'h1;
        @(posedge core_clk);
        #1;
        sync_lost_clear = 1'h0;
        @(posedge core_clk);
        #1;
        cmp_v(sync_lost_flag, 1'h0);
    endtask
    task automatic wait_rise(output int n);
        logic p;
        for (n = 1; n < 1000; n++) begin
            p = tdm_sync_out;
            @(posedge core_clk);
            #1;
            if (p === 1'h0 && tdm_sync_out === 1'h1) break;
        end
    endtask
    // own clock and sync drive the link back into the counter
    task automatic t_gen();
        int n;
        ign = 0;
        gen_enable = 1'h1;
        wait_rise(n);
        wait_rise(n);
        got_ch.delete();
        got_d.delete();
        wait_rise(n);
        cmp_n(n, 2 * DIV * GBITS);
        cmp_n(got_ch.size(), GBITS);
        cmp_n(ign, 0);
        cmp_v(tdm_clk_oe, 1'h1);
        open_drain = 1'h1;
        repeat (2) @(posedge core_clk);
        #1;
        cmp_v(tdm_sync_out, 1'h0);
        gen_enable = 1'h0;
    endtask

    // main sequence: reset, load two entries, run the scenarios
    initial begin
        {rst_n, link_enable, gen_enable, sync_lost_clear, open_drain} = 5'h00;
        {e1_mode, shadow_enable, shadow_select, rt_wr_en, hdlc_frame_end} = 5'h00;
        {hdlc_crc_bad, hdlc_octet_bad, hdlc_len_bad} = 3'h0;
        {rt_wr_addr, hdlc_frame_ch, rt_wr_data} = 28'h0;
        for (int c = 0; c < 64; c++) chan_mode[c] = MODE_OFF;
        chan_mode[3] = MODE_HDLC;
        chan_mode[4] = MODE_TRANS;
        repeat (3) @(posedge core_clk);
        #1;
        rst_n = 1'h1;
        rt_wr_en = 1'h1;
        rt_wr_data = 16'h4507;
        @(posedge core_clk);
        #1;
        rt_wr_addr = 6'h01;
        rt_wr_data = 16'hC907;
        @(posedge core_clk);
        #1;
        rt_wr_en = 1'h0;
        repeat (2) @(posedge core_clk);
        #1;
        e1_mode = 1'h1;
        link_enable = 1'h1;
        t_normal();
        t_missed();
        t_bd();
        t_extra();
        t_gen();
        conclude();
    end
endmodule
`default_nettype wire
